// file: rtl/cag_circ_add.sv
// add/subtract with carry blocked above bit n
`timescale 1ns/1ps
`default_nettype none
module cag_circ_add #(
    parameter int WIDTH = 32
) (
    input wire logic [WIDTH-1:0] base,
    input wire logic [WIDTH-1:0] offset,
    input wire logic subtract,
    input wire logic circular,
    input wire logic [4:0] blockN,
    output logic [WIDTH-1:0] result
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] keepLow;

    // ==========================================
    // in circular mode bits up to n follow the sum, the rest hold
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_mask
            assign keepLow[i] = !circular || (5'(i) <= blockN);
        end
    endgenerate

    assign raw = subtract ? base - offset : base + offset;
    // masking keeps base bits above n in place of the sum, giving the modulo wrap
    assign result = (base & ~keepLow) | (raw & keepLow);
endmodule
`default_nettype wire

// file: rtl/cag_defines.svh
// constants of the circular address generator
`ifndef CAG_DEFINES_SVH
`define CAG_DEFINES_SVH

// ==========================================
// register offsets
`define CAG_MODE_REG_OFS 8'h00
`define CAG_EADDR_OFS 8'h04
`define CAG_COUNT_OFS 8'h08
`define CAG_ILLEGAL_OFS 8'h0c
`define CAG_RESULT_OFS 8'h10

// ==========================================
// addressing mode register layout
`define CAG_MODE_REG_RST 32'h0000_0000
`define CAG_SIZE_FIRST_LSB 16
`define CAG_SIZE_SECOND_LSB 21
`define CAG_BK_W 5
`define CAG_MODE_W 2
`define CAG_MODE_LINEAR 2'h0
`define CAG_MODE_FIRST 2'h1
`define CAG_MODE_SECOND 2'h2
`define CAG_MODE_REG_TEST 32'h0004_0001

// ==========================================
// register numbers and shifts
`define CAG_CIRC_GROUP 3'h1
`define CAG_PAGE_LOW 5'h0e
`define CAG_PAGE_HIGH 5'h0f
`define CAG_SHIFT_WORD 2'h2
`define CAG_SHIFT_HALF 2'h1
`define CAG_SHIFT_BYTE 2'h0
`define CAG_COUNT_RST 16'h0000

`endif

// file: rtl/cag_pkg.sv
// types of the circular address generator
package cag_pkg;

    // ==========================================
    // operation codes
    typedef enum logic [3:0] {
        CAG_K_LOAD = 4'h1,
        CAG_K_STORE = 4'h2,
        CAG_K_ADDA = 4'h4,
        CAG_K_SUBA = 4'h8
    } cag_kind_e;

    typedef enum logic [2:0] {
        CAG_SZ_BYTE = 3'h1,
        CAG_SZ_HALF = 3'h2,
        CAG_SZ_WORD = 3'h4
    } cag_size_e;

    typedef enum logic [2:0] {
        CAG_OFF_REG = 3'h1,
        CAG_OFF_U5 = 3'h2,
        CAG_OFF_U15 = 3'h4
    } cag_off_e;

    typedef enum logic [2:0] {
        CAG_FORM_NONE = 3'h1,
        CAG_FORM_PRE = 3'h2,
        CAG_FORM_POST = 3'h4
    } cag_form_e;

    // ==========================================
    // decoded request and registered answer
    typedef struct packed {
        logic valid;
        cag_kind_e kind;
        cag_size_e size;
        logic sideB;
        logic [4:0] baseIdx;
        cag_off_e offSel;
        cag_form_e form;
        logic decrement;
        logic [31:0] baseOperand;
        logic [31:0] indexOperand;
    } cag_req_s;

    typedef struct packed {
        logic memValid;
        logic memWrite;
        logic [31:0] memAddr;
        logic baseWbValid;
        logic baseWbSideB;
        logic [4:0] baseWbIdx;
        logic [31:0] baseWbVal;
        logic dstValid;
        logic [31:0] dstVal;
        logic illegal;
    } cag_rsp_s;

    typedef struct packed {
        logic [31:0] addrModeReg;
        logic [31:0] lastEaddr;
        logic [31:0] lastResult;
        logic [15:0] memCount;
        logic [15:0] arithCount;
        logic [15:0] illegalCount;
        logic [31:0] regRdata;
        cag_rsp_s rsp;
    } cag_state_s;

endpackage

// file: rtl/cag_scale.sv
// offset scaler by access size
`timescale 1ns/1ps
`default_nettype none
`include "cag_defines.svh"
module cag_scale
    import cag_pkg::*;
(
    input wire logic [31:0] offsetIn,
    input wire cag_size_e size,
    output logic [31:0] offsetOut
);
    always_comb begin
        unique case (size)
            CAG_SZ_WORD: offsetOut = offsetIn << `CAG_SHIFT_WORD;
            CAG_SZ_HALF: offsetOut = offsetIn << `CAG_SHIFT_HALF;
            CAG_SZ_BYTE: offsetOut = offsetIn << `CAG_SHIFT_BYTE;
            default: offsetOut = offsetIn;
        endcase
    end
endmodule
`default_nettype wire

// file: rtl/cag_top.sv
// address generation datapath with register port
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "cag_defines.svh"
module cag_top
    import cag_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    input wire cag_req_s req,
    output cag_rsp_s rsp
);
    cag_state_s st_reg;
    cag_state_s st_next;

    logic isLdSt;
    logic isArith;
    logic kindOk;
    logic circCapable;
    logic [3:0] modeLsb;
    logic [1:0] modeSel;
    logic [4:0] blockN;
    logic circular;
    logic [31:0] offsetSized;
    logic [31:0] offsetScaled;
    logic subtract;
    logic [31:0] newValue;
    logic illegal;
    logic pageBase;

    // ==========================================
    // operation decode
    always_comb begin
        isLdSt = 1'b0;
        isArith = 1'b0;
        kindOk = 1'b1;
        unique case (req.kind)
            CAG_K_LOAD: isLdSt = 1'b1;
            CAG_K_STORE: isLdSt = 1'b1;
            CAG_K_ADDA: isArith = 1'b1;
            CAG_K_SUBA: isArith = 1'b1;
            default: kindOk = 1'b0;
        endcase
    end

    // ==========================================
    // mode select from the addressing mode register
    assign circCapable = (req.baseIdx[4:2] == `CAG_CIRC_GROUP);
    assign modeLsb = {req.sideB, req.baseIdx[1:0], 1'b0};
    assign modeSel = st_reg.addrModeReg[modeLsb +: `CAG_MODE_W];

    always_comb begin
        unique case (modeSel)
            `CAG_MODE_FIRST: blockN = st_reg.addrModeReg[`CAG_SIZE_FIRST_LSB +: `CAG_BK_W];
            `CAG_MODE_SECOND: blockN = st_reg.addrModeReg[`CAG_SIZE_SECOND_LSB +: `CAG_BK_W];
            default: blockN = 5'h1f;
        endcase
    end

    // reserved mode code falls back to linear
    assign circular = circCapable && (isLdSt || isArith) &&
                      ((modeSel == `CAG_MODE_FIRST) || (modeSel == `CAG_MODE_SECOND));

    // ==========================================
    // offset selection and scaling
    always_comb begin
        unique case (req.offSel)
            CAG_OFF_REG: offsetSized = req.indexOperand;
            CAG_OFF_U5: offsetSized = {27'h0, req.indexOperand[4:0]};
            CAG_OFF_U15: offsetSized = {17'h0, req.indexOperand[14:0]};
            default: offsetSized = 32'h0;
        endcase
    end

    cag_scale u_scale (
        .offsetIn(offsetSized),
        .size(req.size),
        .offsetOut(offsetScaled)
    );

    assign subtract = (req.kind == CAG_K_SUBA) || (isLdSt && req.decrement);

    cag_circ_add #(
        .WIDTH(32)
    ) u_add (
        .base(req.baseOperand),
        .offset(offsetScaled),
        .subtract(subtract),
        .circular(circular),
        .blockN(blockN),
        .result(newValue)
    );

    // ==========================================
    // illegal combinations
    assign pageBase = req.sideB &&
                      ((req.baseIdx == `CAG_PAGE_LOW) || (req.baseIdx == `CAG_PAGE_HIGH));
    always_comb begin
        illegal = !kindOk;
        if (req.offSel == CAG_OFF_U15) begin
            if (!pageBase || isArith || req.decrement || (req.form != CAG_FORM_NONE)) begin
                illegal = 1'b1;
            end
        end
        if (isLdSt && !(req.form inside {CAG_FORM_NONE, CAG_FORM_PRE, CAG_FORM_POST})) begin
            illegal = 1'b1;
        end
        if (!(req.offSel inside {CAG_OFF_REG, CAG_OFF_U5, CAG_OFF_U15})) begin
            illegal = 1'b1;
        end
        if (!(req.size inside {CAG_SZ_BYTE, CAG_SZ_HALF, CAG_SZ_WORD})) begin
            illegal = 1'b1;
        end
    end

    // ==========================================
    // next state
    always_comb begin
        st_next = st_reg;
        st_next.rsp.memValid = 1'b0;
        st_next.rsp.memWrite = 1'b0;
        st_next.rsp.baseWbValid = 1'b0;
        st_next.rsp.dstValid = 1'b0;
        st_next.rsp.illegal = 1'b0;
        st_next.regRdata = 32'h0;

        // register writes
        if (regWrite) begin
            if (regAddr == ADDR_W'(`CAG_MODE_REG_OFS)) begin
                st_next.addrModeReg = regWdata;
            end
            if (regAddr == ADDR_W'(`CAG_COUNT_OFS)) begin
                st_next.memCount = `CAG_COUNT_RST;
                st_next.arithCount = `CAG_COUNT_RST;
            end
            if (regAddr == ADDR_W'(`CAG_ILLEGAL_OFS)) begin
                st_next.illegalCount = `CAG_COUNT_RST;
            end
        end

        // register reads, unmapped reads as zero
        if (regRead) begin
            if (regAddr == ADDR_W'(`CAG_MODE_REG_OFS)) begin
                st_next.regRdata = st_reg.addrModeReg;
            end else if (regAddr == ADDR_W'(`CAG_EADDR_OFS)) begin
                st_next.regRdata = st_reg.lastEaddr;
            end else if (regAddr == ADDR_W'(`CAG_COUNT_OFS)) begin
                st_next.regRdata = {st_reg.arithCount, st_reg.memCount};
            end else if (regAddr == ADDR_W'(`CAG_ILLEGAL_OFS)) begin
                st_next.regRdata = {16'h0, st_reg.illegalCount};
            end else if (regAddr == ADDR_W'(`CAG_RESULT_OFS)) begin
                st_next.regRdata = st_reg.lastResult;
            end
        end

        // datapath; counts after a clear so the event wins
        if (req.valid) begin
            if (illegal) begin
                st_next.rsp.illegal = 1'b1;
                st_next.illegalCount = st_next.illegalCount + 16'h1;
            end else if (isLdSt) begin
                st_next.rsp.memValid = 1'b1;
                st_next.rsp.memWrite = (req.kind == CAG_K_STORE);
                st_next.memCount = st_next.memCount + 16'h1;
                unique case (req.form)
                    CAG_FORM_POST: begin
                        st_next.rsp.memAddr = req.baseOperand;
                        st_next.rsp.baseWbValid = 1'b1;
                    end
                    CAG_FORM_PRE: begin
                        st_next.rsp.memAddr = newValue;
                        st_next.rsp.baseWbValid = 1'b1;
                    end
                    default: begin
                        st_next.rsp.memAddr = newValue;
                    end
                endcase
                st_next.rsp.baseWbSideB = req.sideB;
                st_next.rsp.baseWbIdx = req.baseIdx;
                st_next.rsp.baseWbVal = newValue;
                st_next.lastEaddr = st_next.rsp.memAddr;
            end else begin
                st_next.rsp.dstValid = 1'b1;
                st_next.rsp.dstVal = newValue;
                st_next.arithCount = st_next.arithCount + 16'h1;
                st_next.lastResult = newValue;
            end
        end
    end

    // ==========================================
    // state register
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
            st_reg.addrModeReg <= `CAG_MODE_REG_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign regRdata = st_reg.regRdata;
    assign rsp = st_reg.rsp;
endmodule
`default_nettype wire

// file: test/cag_mem_model.sv
// memory path model counting accesses
`timescale 1ns/1ps
`default_nettype none
module cag_mem_model
    import cag_pkg::*;
(
    input wire logic ref_clk,
    input wire cag_rsp_s rsp,
    output var int accCount
);
    // ==========================================
    // access counter
    int accTotal = 0;
    always @(posedge ref_clk) begin
        if (rsp.memValid) begin
            accTotal <= accTotal + 1;
        end
    end
    assign accCount = accTotal;
endmodule
`default_nettype wire

// file: test/cag_top_checker.sv
// assertions on the address generator ports
`timescale 1ns/1ps
`default_nettype none
module cag_top_checker
    import cag_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regRdata,
    input wire cag_req_s req,
    input wire cag_rsp_s rsp
);
    logic [31:0] modeTrk;
    logic [31:0] hiMask;
    logic ldReg;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // ==========================================
    // helper logic
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            modeTrk <= 32'h0;
        end else if (regWrite && regAddr == '0) begin
            modeTrk <= regWdata;
        end
    end
    assign hiMask = 32'hffffffff << ({1'b0, modeTrk[20:16]} + 6'h1);
    assign ldReg = req.valid && req.kind == CAG_K_LOAD && req.offSel == CAG_OFF_REG;
    // ==========================================
    // properties
    a_mem_cause: assert property (rsp.memValid |-> $past(req.valid)
        && $past(req.kind) inside {CAG_K_LOAD, CAG_K_STORE}) else $error("stray memory access");
    a_store_flag: assert property (rsp.memValid |->
        rsp.memWrite == ($past(req.kind) == CAG_K_STORE)) else $error("write flag wrong");
    a_linear_word: assert property (ldReg && req.size == CAG_SZ_WORD
        && req.form == CAG_FORM_NONE && !req.decrement && req.baseIdx < 5'h4
        |=> rsp.memAddr == $past(req.baseOperand) + ($past(req.indexOperand) << 2))
        else $error("linear word address wrong");
    a_post_old: assert property (ldReg && req.form == CAG_FORM_POST
        |=> rsp.memAddr == $past(req.baseOperand) && rsp.baseWbValid) else $error("post form wrong");
    a_circ_keep: assert property (req.valid && req.kind == CAG_K_ADDA && !req.sideB
        && req.baseIdx == 5'h4 && modeTrk[1:0] == 2'h1 |=> rsp.dstValid
        && ((rsp.dstVal ^ $past(req.baseOperand)) & $past(hiMask)) == 32'h0)
        else $error("circular high bits changed");
    a_u15_refuse: assert property (req.valid && req.offSel == CAG_OFF_U15
        && req.form != CAG_FORM_NONE |=> rsp.illegal && !rsp.memValid && !rsp.baseWbValid)
        else $error("modified long offset taken");
    a_u15_page: assert property (req.valid && req.kind == CAG_K_LOAD && req.sideB
        && req.offSel == CAG_OFF_U15 && req.baseIdx == 5'h0f && req.form == CAG_FORM_NONE
        && !req.decrement |=> rsp.memValid && !rsp.illegal) else $error("page base refused");
    a_mode_read: assert property (regRead && regAddr == '0
        |=> regRdata == modeTrk) else $error("mode readback wrong");
    a_arith_nomem: assert property (req.valid && req.kind inside {CAG_K_ADDA, CAG_K_SUBA}
        |=> rsp.dstValid && !rsp.memValid) else $error("arithmetic result missing");
endmodule
bind cag_top cag_top_checker #(.ADDR_W(ADDR_W)) cag_top_checker_i (.ref_clk(ref_clk),
    .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .req(req), .rsp(rsp));
`default_nettype wire

// file: test/cag_top_tb.sv
// self-checking bench of the address generator
`timescale 1ns/1ps
`default_nettype none
`include "cag_defines.svh"
module cag_top_tb
    import cag_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] regAddr = 8'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [31:0] regRdata;
    logic [31:0] modeShadow = 32'h0;
    logic [31:0] rd;
    logic [31:0] want;
    logic isMem;
    cag_req_s req = '0;
    cag_req_s r;
    cag_rsp_s rsp;
    int num_errors = 0;
    int compares = 0;
    int accCount;
    int acc0;
    int cyc = 0;
    int nMem = 0;
    int nAr = 0;
    cag_top cag_top_i (.ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .req(req), .rsp(rsp));
    cag_mem_model cag_mem_model_i (.ref_clk(ref_clk), .rsp(rsp), .accCount(accCount));
    initial forever #5 ref_clk = ~ref_clk;
    // ==========================================
    // tasks
    task automatic finish_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        if (a == 8'h00) modeShadow = d;
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 rd = regRdata;
    endtask
    task automatic send(input cag_req_s q);
        @(posedge ref_clk);
        req <= q;
        @(posedge ref_clk);
        req.valid <= 1'b0;
        #1;
    endtask
    function automatic logic [31:0] calc(input cag_req_s q, input logic [31:0] m);
        logic [1:0] md;
        logic [4:0] n;
        logic [31:0] off;
        logic [31:0] low;
        logic [31:0] s;
        md = m[2 * int'({q.sideB, q.baseIdx[1:0]}) +: 2];
        n = (md == 2'h1) ? m[20:16] : m[25:21];
        off = (q.offSel == CAG_OFF_U5) ? {27'h0, q.indexOperand[4:0]} : q.indexOperand;
        off = off << (q.size == CAG_SZ_WORD ? 2 : q.size == CAG_SZ_HALF ? 1 : 0);
        s = (q.kind == CAG_K_SUBA || q.decrement) ? q.baseOperand - off : q.baseOperand + off;
        low = (32'h2 << n) - 32'h1;
        if (q.baseIdx[4:2] == 3'h1 && (md == 2'h1 || md == 2'h2)) s = (q.baseOperand & ~low) | (s & low);
        return s;
    endfunction
    // ==========================================
    // main sequence
    initial begin
        void'($urandom(48));
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        rdr(8'h00);
        chk(rd, 32'h0);
        rdr(8'h1c);
        chk(rd, 32'h0);
        wr(8'h00, `CAG_MODE_REG_TEST);
        rdr(8'h00);
        chk(rd, 32'h0004_0001);
        send('{1'b1, CAG_K_LOAD, CAG_SZ_WORD, 1'b0, 5'h4, CAG_OFF_REG, CAG_FORM_POST, 1'b0, 32'h100, 32'h9});
        chk(rsp.memAddr, 32'h100);
        chk(rsp.baseWbVal, 32'h104);
        chk({26'h0, rsp.baseWbSideB, rsp.baseWbIdx}, 32'h4);
        send('{1'b1, CAG_K_ADDA, CAG_SZ_HALF, 1'b0, 5'h4, CAG_OFF_REG, CAG_FORM_NONE, 1'b0, 32'h100, 32'h13});
        chk(rsp.dstVal, 32'h106);
        send('{1'b1, CAG_K_LOAD, CAG_SZ_WORD, 1'b0, 5'h2, CAG_OFF_REG, CAG_FORM_NONE, 1'b0, 32'h200, 32'h3});
        chk(rsp.memAddr, 32'h20c);
        send('{1'b1, CAG_K_LOAD, CAG_SZ_WORD, 1'b1, 5'h0f, CAG_OFF_U15, CAG_FORM_NONE, 1'b0, 32'h1000, 32'h7fff});
        chk(rsp.memAddr, 32'h20ffc);
        send('{1'b1, CAG_K_LOAD, CAG_SZ_WORD, 1'b1, 5'h0f, CAG_OFF_U15, CAG_FORM_PRE, 1'b0, 32'h1000, 32'h4});
        chk({31'h0, rsp.illegal}, 32'h1);
        rdr(8'h04);
        chk(rd, 32'h20ffc);
        rdr(8'h10);
        chk(rd, 32'h106);
        rdr(8'h0c);
        chk(rd, 32'h1);
        wr(8'h08, 32'h0);
        acc0 = accCount;
        repeat (60) begin
            if ($urandom % 4 == 0) wr(8'h00, $urandom & 32'h03ff_ffff);
            r = '0;
            r.valid = 1'b1;
            r.kind = cag_kind_e'(4'h1 << ($urandom % 4));
            r.size = cag_size_e'(3'h1 << ($urandom % 3));
            r.sideB = 1'($urandom);
            r.baseIdx = 5'($urandom % 10);
            r.offSel = ($urandom % 2) ? CAG_OFF_U5 : CAG_OFF_REG;
            r.form = cag_form_e'(3'h1 << ($urandom % 3));
            r.decrement = r.kind[1:0] != 2'h0 && 1'($urandom);
            r.baseOperand = $urandom;
            r.indexOperand = $urandom % 64;
            isMem = r.kind[1:0] != 2'h0;
            want = calc(r, modeShadow);
            send(r);
            chk(isMem ? rsp.memAddr : rsp.dstVal, (isMem && r.form == CAG_FORM_POST) ? r.baseOperand : want);
            chk({31'h0, rsp.baseWbValid}, {31'h0, isMem && r.form != CAG_FORM_NONE});
            if (isMem && r.form != CAG_FORM_NONE) begin
                chk(rsp.baseWbVal, want);
                chk({26'h0, rsp.baseWbSideB, rsp.baseWbIdx}, {26'h0, r.sideB, r.baseIdx});
            end
            nMem += int'(r.kind[1:0] != 2'h0);
            nAr += int'(r.kind[1:0] == 2'h0);
        end
        rdr(8'h08);
        chk(rd, {nAr[15:0], nMem[15:0]});
        chk(accCount - acc0, nMem);
        finish_test();
    end
endmodule
`default_nettype wire
